// ==== shared/mmncs_pkg.sv ====
// What this block does
// - Engaged navigation adopts received bearing as course.
// - Cross-track holds line; bearing corrects larger turns.
// - Bearing unchanged 30-60 s selects cross-track steering.
// - Leave cross-track when bearing moves over 5 degrees.
// - Bearing jump over 10 degrees needs acknowledgement.
// - Unchanged-bearing timeout follows message repetition rate.
// - Navigation correction limited to 32 degrees either way.
// - Course error is heading minus set course.
// - Rudder demand only beyond the configured allowance.
// - Inputs polled in turn from one clock.
// - Excite compass, take converter sample, compute heading.
// - Two-phase selector pulses give direction and amount.
// - Bearing within 10 degrees accepted automatically.
// - Jump shows requested heading, alarm pulses 20 s.
// - Navigation-auto-navigation during alarm silences and adopts.
// - One degree of course per selector pulse.
package mmncs_pkg;
    typedef logic [8:0] mmncs_deg_t;
    typedef logic signed [9:0] mmncs_sdeg_t;
    typedef struct packed {
        logic valid;
        mmncs_deg_t deg;
    } mmncs_brg_s;
    typedef struct packed {
        logic valid;
        logic signed [7:0] corr;
    } mmncs_xtk_s;
    typedef enum logic [1:0] {
        P_EXCITE = 2'h0,
        P_ADC = 2'h1,
        P_SEL = 2'h3,
        P_NAV = 2'h2
    } mmncs_poll_e;

    localparam int ADC_W = 12;
    localparam logic [8:0] DEG_FULL_U = 9'h168;
    localparam logic signed [10:0] DEG_FULL = 11'sh168;
    localparam logic signed [10:0] DEG_HALF = 11'sh0b4;
    localparam mmncs_sdeg_t XTK_EXIT_DEG = 10'sh005;
    localparam mmncs_sdeg_t ACK_LIMIT_DEG = 10'sh00a;
    localparam mmncs_sdeg_t NAV_CORR_DEG = 10'sh020;
    localparam logic signed [5:0] SEL_STEP = 6'sh01;
    localparam int ALARM_BEAT_BIT = 24;

    localparam longint CLK_HZ = 40_000_000;
    localparam longint XTAL_HZ = 6_000_000;
    localparam longint STILL_MIN_S = 30;
    localparam longint STILL_MAX_S = 60;
    localparam longint ALARM_S = 20;
    localparam longint ADC_WAIT_NS = 1600;
    localparam longint STILL_MIN_CYC = STILL_MIN_S * CLK_HZ;
    localparam longint STILL_MAX_CYC = STILL_MAX_S * CLK_HZ;
    localparam longint ALARM_CYC = ALARM_S * CLK_HZ;
    localparam longint POLL_DWELL_CYC = CLK_HZ / XTAL_HZ;
    localparam longint ADC_WAIT_CYC = ADC_WAIT_NS * CLK_HZ / 1_000_000_000;

    function automatic mmncs_deg_t deg_wrap(input logic signed [10:0] x);
        logic signed [10:0] y;
        y = x;
        if (y < 0) begin
            y = y + DEG_FULL;
        end else if (y >= DEG_FULL) begin
            y = y - DEG_FULL;
        end
        return y[8:0];
    endfunction : deg_wrap

    function automatic mmncs_sdeg_t deg_diff(input mmncs_deg_t a, input mmncs_deg_t b);
        logic signed [10:0] d;
        d = signed'({2'b00, a}) - signed'({2'b00, b});
        if (d >= DEG_HALF) begin
            d = d - DEG_FULL;
        end else if (d < -DEG_HALF) begin
            d = d + DEG_FULL;
        end
        return d[9:0];
    endfunction : deg_diff

    function automatic mmncs_sdeg_t deg_abs(input mmncs_sdeg_t d);
        return (d < 0) ? -d : d;
    endfunction : deg_abs

    function automatic mmncs_deg_t deg_from_adc(input logic [ADC_W-1:0] s);
        logic [20:0] p;
        p = 21'(s) * 21'(DEG_FULL_U);
        return p[20:12];
    endfunction : deg_from_adc
endpackage : mmncs_pkg

// ==== rtl/mmncs_sel_decoder.sv ====
`timescale 1ns/1ps
module mmncs_sel_decoder (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic phase_a_i,
    input wire logic phase_b_i,
    output logic step_o,
    output logic step_up_o
);
    logic a_q;
    logic step_q;
    logic up_q;
    logic step_d;
    logic up_d;

    // Each rising edge of phase A is one tooth; phase B tells the direction.
    always_comb begin
        step_d = phase_a_i & ~a_q;
        up_d = step_d ? ~phase_b_i : up_q;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            a_q <= 1'b0;
            step_q <= 1'b0;
            up_q <= 1'b0;
        end else begin
            a_q <= phase_a_i;
            step_q <= step_d;
            up_q <= up_d;
        end
    end

    assign step_o = step_q;
    assign step_up_o = up_q;

    a_step_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (phase_a_i && !a_q) |=> (step_o && step_up_o == !$past(phase_b_i)))
        else $error("Selector tooth did not give one step.");
endmodule : mmncs_sel_decoder

// ==== rtl/mmncs_top.sv ====
`timescale 1ns/1ps
module mmncs_top #(
    parameter logic [31:0] STILL_MIN_CYC = 32'(mmncs_pkg::STILL_MIN_CYC),
    parameter logic [31:0] STILL_MAX_CYC = 32'(mmncs_pkg::STILL_MAX_CYC),
    parameter logic [31:0] ALARM_CYC = 32'(mmncs_pkg::ALARM_CYC)
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mode_nav_i,
    input wire mmncs_pkg::mmncs_brg_s bearing_i,
    input wire mmncs_pkg::mmncs_xtk_s cross_track_error_i,
    input wire logic [mmncs_pkg::ADC_W-1:0] adc_data_i,
    input wire logic adc_valid_i,
    input wire logic sel_phase_a_i,
    input wire logic sel_phase_b_i,
    input wire mmncs_pkg::mmncs_deg_t allowance_i,
    output logic compass_excite_o,
    output mmncs_pkg::mmncs_deg_t heading_o,
    output mmncs_pkg::mmncs_deg_t course_ref_o,
    output mmncs_pkg::mmncs_deg_t set_course_o,
    output mmncs_pkg::mmncs_sdeg_t course_error_o,
    output mmncs_pkg::mmncs_sdeg_t rudder_cmd_o,
    output logic steer_cross_track_o,
    output logic alarm_o,
    output mmncs_pkg::mmncs_deg_t display_b_o,
    output logic display_b_valid_o
);
    import mmncs_pkg::*;

    localparam logic [3:0] DWELL_LAST = 4'(POLL_DWELL_CYC - 1);
    localparam logic [7:0] ADC_WAIT_LAST = 8'(ADC_WAIT_CYC - 1);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    mmncs_poll_e poll_q, poll_d;
    logic [3:0] dwell_q, dwell_d;
    logic [7:0] wait_q, wait_d;
    logic excite_q, excite_d;
    mmncs_deg_t heading_q, heading_d;
    logic tick;

    assign tick = (dwell_q == DWELL_LAST);

    // One slot per input in turn; the converter slot may end early on its answer.
    always_comb begin
        poll_d = poll_q;
        dwell_d = tick ? '0 : dwell_q + 4'h1;
        wait_d = wait_q;
        excite_d = 1'b0;
        heading_d = heading_q;
        case (poll_q)
            P_EXCITE: begin
                if (tick) begin
                    excite_d = 1'b1;
                    wait_d = '0;
                    poll_d = P_ADC;
                end
            end
            P_ADC: begin
                wait_d = wait_q + 8'h01;
                if (adc_valid_i) begin
                    heading_d = deg_from_adc(adc_data_i);
                    poll_d = P_SEL;
                end else if (wait_q == ADC_WAIT_LAST) begin
                    poll_d = P_SEL;
                end
            end
            P_SEL: begin
                if (tick) begin
                    poll_d = P_NAV;
                end
            end
            P_NAV: begin
                if (tick) begin
                    poll_d = P_EXCITE;
                end
            end
            default: begin
                poll_d = P_EXCITE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            poll_q <= P_EXCITE;
            dwell_q <= '0;
            wait_q <= '0;
            excite_q <= 1'b0;
            heading_q <= '0;
        end else begin
            poll_q <= poll_d;
            dwell_q <= dwell_d;
            wait_q <= wait_d;
            excite_q <= excite_d;
            heading_q <= heading_d;
        end
    end

    logic sel_step, sel_up, sel_take;
    logic signed [5:0] sel_acc_q, sel_acc_d;
    mmncs_deg_t course_ref_q, course_ref_d;

    mmncs_sel_decoder u_sel (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .phase_a_i(sel_phase_a_i),
        .phase_b_i(sel_phase_b_i),
        .step_o(sel_step),
        .step_up_o(sel_up)
    );

    assign sel_take = (poll_q == P_SEL) && tick;

    // Steps that arrive while the slot consumes the total are kept, not lost.
    always_comb begin
        sel_acc_d = sel_take ? '0 : sel_acc_q;
        if (sel_step) begin
            sel_acc_d = sel_up ? sel_acc_d + SEL_STEP : sel_acc_d - SEL_STEP;
        end
        course_ref_d = course_ref_q;
        if (sel_take) begin
            course_ref_d = deg_wrap(signed'({2'b00, course_ref_q}) + 11'(sel_acc_q));
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_acc_q <= '0;
            course_ref_q <= '0;
        end else begin
            sel_acc_q <= sel_acc_d;
            course_ref_q <= course_ref_d;
        end
    end

    logic nav_q, nav_d, brg_new_q, brg_new_d;
    mmncs_deg_t brg_hold_q, brg_hold_d;
    logic signed [7:0] xtk_q, xtk_d;
    logic steer_q, steer_d, fresh_q, fresh_d;
    mmncs_deg_t ref_q, ref_d, target_q, target_d, pend_q, pend_d;
    logic [31:0] still_q, still_d, alarm_cnt_q, alarm_cnt_d;
    logic alarm_q, alarm_d, left_q, left_d, beep_q, beep_d;
    logic nav_take, rise, ack, changed, big, acc_go;
    mmncs_sdeg_t d_ref;

    assign nav_take = (poll_q == P_NAV) && tick;
    assign rise = mode_nav_i && !nav_q;
    assign ack = rise && alarm_q && left_q;
    assign d_ref = deg_abs(deg_diff(brg_hold_q, ref_q));
    assign changed = (brg_hold_q != ref_q) || fresh_q;
    assign big = deg_abs(deg_diff(brg_hold_q, set_course_o)) > ACK_LIMIT_DEG;

    always_comb begin
        nav_d = mode_nav_i;
        brg_new_d = (nav_take ? 1'b0 : brg_new_q) | bearing_i.valid;
        brg_hold_d = bearing_i.valid ? bearing_i.deg : brg_hold_q;
        xtk_d = cross_track_error_i.valid ? cross_track_error_i.corr : xtk_q;
        steer_d = steer_q;
        fresh_d = fresh_q;
        ref_d = ref_q;
        target_d = target_q;
        pend_d = pend_q;
        left_d = left_q;
        acc_go = 1'b0;
        still_d = (still_q == STILL_MAX_CYC) ? still_q : still_q + 32'h0000_0001;
        alarm_d = alarm_q;
        alarm_cnt_d = alarm_q ? alarm_cnt_q + 32'h0000_0001 : '0;
        if (alarm_q && alarm_cnt_q == ALARM_CYC - 32'h0000_0001) begin
            alarm_d = 1'b0;
        end
        if (!mode_nav_i) begin
            steer_d = 1'b0;
            still_d = '0;
            fresh_d = 1'b1;
            target_d = course_ref_q;
            if (alarm_q && nav_q) begin
                left_d = 1'b1;
            end
        end else if (ack) begin
            target_d = pend_q;
            ref_d = pend_q;
            alarm_d = 1'b0;
            left_d = 1'b0;
            fresh_d = 1'b0;
            still_d = '0;
        end else if (rise) begin
            brg_new_d = 1'b1;
            left_d = 1'b0;
        end else if (nav_take && brg_new_q) begin
            if (steer_q) begin
                if (d_ref > XTK_EXIT_DEG) begin
                    steer_d = 1'b0;
                    acc_go = 1'b1;
                end
            end else if (changed) begin
                acc_go = 1'b1;
            end else if (still_q >= STILL_MIN_CYC) begin
                steer_d = 1'b1;
            end
        end else if (!steer_q && still_q >= STILL_MAX_CYC) begin
            steer_d = 1'b1;
        end
        if (acc_go) begin
            still_d = '0;
            fresh_d = 1'b0;
            ref_d = brg_hold_q;
            if (big) begin
                pend_d = brg_hold_q;
                alarm_d = 1'b1;
                alarm_cnt_d = '0;
                left_d = 1'b0;
            end else begin
                target_d = brg_hold_q;
            end
        end
        beep_d = alarm_d && alarm_cnt_d[ALARM_BEAT_BIT];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nav_q <= 1'b0;
            brg_new_q <= 1'b0;
            brg_hold_q <= '0;
            xtk_q <= '0;
            steer_q <= 1'b0;
            fresh_q <= 1'b1;
            ref_q <= '0;
            target_q <= '0;
            pend_q <= '0;
            still_q <= '0;
            alarm_q <= 1'b0;
            alarm_cnt_q <= '0;
            left_q <= 1'b0;
            beep_q <= 1'b0;
        end else begin
            nav_q <= nav_d;
            brg_new_q <= brg_new_d;
            brg_hold_q <= brg_hold_d;
            xtk_q <= xtk_d;
            steer_q <= steer_d;
            fresh_q <= fresh_d;
            ref_q <= ref_d;
            target_q <= target_d;
            pend_q <= pend_d;
            still_q <= still_d;
            alarm_q <= alarm_d;
            alarm_cnt_q <= alarm_cnt_d;
            left_q <= left_d;
            beep_q <= beep_d;
        end
    end

    mmncs_deg_t set_q, set_d, base;
    mmncs_sdeg_t off, err_q, err_d, rud_q, rud_d;

    // The clamp keeps a bad fix from turning the boat far from the chosen course.
    always_comb begin
        base = steer_q ? deg_wrap(signed'({2'b00, target_q}) + 11'(xtk_q)) : target_q;
        off = deg_diff(base, course_ref_q);
        if (off > NAV_CORR_DEG) begin
            off = NAV_CORR_DEG;
        end else if (off < -NAV_CORR_DEG) begin
            off = -NAV_CORR_DEG;
        end
        set_d = (mode_nav_i && nav_q) ?
            deg_wrap(signed'({2'b00, course_ref_q}) + 11'(off)) : course_ref_q;
        err_d = deg_diff(heading_q, set_q);
        rud_d = (deg_abs(err_d) > signed'({1'b0, allowance_i})) ? err_d : '0;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            set_q <= '0;
            err_q <= '0;
            rud_q <= '0;
        end else begin
            set_q <= set_d;
            err_q <= err_d;
            rud_q <= rud_d;
        end
    end

    assign compass_excite_o = excite_q;
    assign heading_o = heading_q;
    assign course_ref_o = course_ref_q;
    assign set_course_o = set_q;
    assign course_error_o = err_q;
    assign rudder_cmd_o = rud_q;
    assign steer_cross_track_o = steer_q;
    assign alarm_o = beep_q;
    assign display_b_o = pend_q;
    assign display_b_valid_o = alarm_q;

    a_excite_pulse: assert property (compass_excite_o |-> poll_q == P_ADC ##1 !compass_excite_o)
        else $error("Compass excitation not a single pulse.");
    a_heading_adc: assert property ((poll_q == P_ADC && adc_valid_i)
        |=> heading_o == deg_from_adc($past(adc_data_i)) && poll_q == P_SEL)
        else $error("Heading not taken from converter sample.");
    a_poll_wrap: assert property ((poll_q == P_NAV && tick) |=> poll_q == P_EXCITE)
        else $error("Polling loop did not return to compass slot.");
    a_sel_step: assert property ((sel_take && sel_acc_q == SEL_STEP)
        |=> course_ref_q == deg_wrap(signed'({2'b00, $past(course_ref_q)}) + 11'sh001))
        else $error("Selector pulse did not move course one degree.");
    a_nav_limit: assert property (($past(nav_q) && nav_q)
        |-> deg_abs(deg_diff(set_course_o, $past(course_ref_q))) <= NAV_CORR_DEG)
        else $error("Navigation correction beyond limit.");
    a_error_calc: assert property (1'b1 |=>
        course_error_o == deg_diff($past(heading_q), $past(set_q)))
        else $error("Course error not heading minus set course.");
    a_rudder_gate: assert property (rudder_cmd_o != '0 |-> rudder_cmd_o == course_error_o
        && deg_abs(course_error_o) > signed'({1'b0, $past(allowance_i)}))
        else $error("Rudder demand inside allowance.");
    a_jump_held: assert property ((acc_go && big) |=> alarm_q && display_b_valid_o
        && target_q == $past(target_q) && display_b_o == $past(brg_hold_q))
        else $error("Large bearing jump adopted without acknowledgement.");
    a_small_take: assert property ((acc_go && !big) |=> target_q == $past(brg_hold_q))
        else $error("Small bearing change not adopted.");
    a_alarm_len: assert property (alarm_q |-> alarm_cnt_q < ALARM_CYC)
        else $error("Alarm ran past its duration.");
    a_ack_adopt: assert property (ack |=> !alarm_q && target_q == $past(pend_q))
        else $error("Acknowledge did not adopt bearing.");
    a_track_exit: assert property ((nav_take && brg_new_q && steer_q && mode_nav_i
        && d_ref > XTK_EXIT_DEG) |=> !steer_q)
        else $error("Cross-track steering kept despite bearing move.");
    a_track_enter: assert property ($rose(steer_q) |-> $past(still_q) >= STILL_MIN_CYC)
        else $error("Cross-track steering entered too early.");

    c_jump_alarm: cover property (acc_go && big);
    c_ack: cover property (ack);
    c_enter_track: cover property ($rose(steer_q));
    c_leave_track: cover property ($fell(steer_q) && mode_nav_i);
endmodule : mmncs_top

// ==== sim/mmncs_nav_rx_model.sv ====
`timescale 1ns/1ps
module mmncs_nav_rx_model (
    input wire logic clk_i,
    output mmncs_pkg::mmncs_brg_s bearing_o,
    output mmncs_pkg::mmncs_xtk_s cross_track_error_o
);
    import mmncs_pkg::*;

    initial begin
        bearing_o = '{valid: 1'b0, deg: 9'h0aa};
        cross_track_error_o = '{valid: 1'b0, corr: 8'h55};
    end

    // The lag stands for the receiver's sentence spacing, so a caller can be prompt or slow.
    // Outside the valid cycle the data is inverted, so the block cannot live off a stale value.
    task automatic send_bearing(input mmncs_deg_t deg, input int lag);
        repeat (lag) @(posedge clk_i);
        @(posedge clk_i);
        bearing_o <= '{valid: 1'b1, deg: deg};
        @(posedge clk_i);
        bearing_o <= '{valid: 1'b0, deg: ~deg};
    endtask : send_bearing

    task automatic send_cross_track_error(input logic signed [7:0] corr, input int lag);
        repeat (lag) @(posedge clk_i);
        @(posedge clk_i);
        cross_track_error_o <= '{valid: 1'b1, corr: corr};
        @(posedge clk_i);
        cross_track_error_o <= '{valid: 1'b0, corr: ~corr};
    endtask : send_cross_track_error
endmodule : mmncs_nav_rx_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import mmncs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic mode_nav_i = 1'b0;
    mmncs_brg_s bearing_i;
    mmncs_xtk_s cross_track_error_i;
    logic [ADC_W-1:0] adc_data_i = 12'h000;
    logic adc_valid_i = 1'b0;
    logic sel_phase_a_i = 1'b0;
    logic sel_phase_b_i = 1'b0;
    mmncs_deg_t allowance_i = 9'h000;
    logic compass_excite_o, steer_cross_track_o, alarm_o, display_b_valid_o;
    mmncs_deg_t heading_o, course_ref_o, set_course_o, display_b_o;
    mmncs_sdeg_t course_error_o, rudder_cmd_o;
    int n_mismatch = 0;
    int check_count = 0;

    always #12.5 clk_i = ~clk_i;

    // Short timeouts keep the run small; every figure below is worked from them.
    mmncs_top #(.STILL_MIN_CYC(32'h0000_00c8), .STILL_MAX_CYC(32'h0000_0320),
        .ALARM_CYC(32'h0000_012c)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .mode_nav_i(mode_nav_i), .bearing_i(bearing_i),
        .cross_track_error_i(cross_track_error_i), .adc_data_i(adc_data_i),
        .adc_valid_i(adc_valid_i), .sel_phase_a_i(sel_phase_a_i),
        .sel_phase_b_i(sel_phase_b_i), .allowance_i(allowance_i),
        .compass_excite_o(compass_excite_o), .heading_o(heading_o),
        .course_ref_o(course_ref_o), .set_course_o(set_course_o),
        .course_error_o(course_error_o), .rudder_cmd_o(rudder_cmd_o),
        .steer_cross_track_o(steer_cross_track_o), .alarm_o(alarm_o),
        .display_b_o(display_b_o), .display_b_valid_o(display_b_valid_o));

    mmncs_nav_rx_model rx (
        .clk_i(clk_i), .bearing_o(bearing_i), .cross_track_error_o(cross_track_error_i));

    task automatic bad(input logic [15:0] got, input logic [15:0] exp);
        n_mismatch++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    endtask : bad

    task automatic check_deg(input mmncs_deg_t got, input mmncs_deg_t exp);
        check_count++;
        if (got !== exp) bad(16'(got), 16'(exp));
    endtask : check_deg

    task automatic check_sdeg(input mmncs_sdeg_t got, input mmncs_sdeg_t exp);
        check_count++;
        if (got !== exp) bad(16'(got), 16'(exp));
    endtask : check_sdeg

    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) bad(16'(got), 16'(exp));
    endtask : check_bit

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_cyc

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic adc_sample(input logic [ADC_W-1:0] s);
        int k;
        k = 0;
        while (compass_excite_o !== 1'b1 && k < 200) begin
            @(negedge clk_i);
            k++;
        end
        check_bit(compass_excite_o, 1'b1);
        @(posedge clk_i);
        adc_valid_i <= 1'b1;
        adc_data_i <= s;
        @(posedge clk_i);
        adc_valid_i <= 1'b0;
        adc_data_i <= ~s;
        wait_cyc(2);
    endtask : adc_sample

    task automatic sel_pulses(input int n, input logic up);
        @(posedge clk_i);
        sel_phase_b_i <= ~up;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            sel_phase_a_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            sel_phase_a_i <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask : sel_pulses

    task automatic t_reset_values();
        wait_cyc(2);
        check_deg(set_course_o, 9'h000);
        check_bit(steer_cross_track_o, 1'b0);
        check_bit(display_b_valid_o, 1'b0);
        check_bit(alarm_o, 1'b0);
    endtask : t_reset_values

    // Full-scale sample sits just below 360, so the error must wrap to minus one.
    task automatic t_heading();
        adc_sample(12'hfff);
        check_deg(heading_o, 9'h167);
        wait_cyc(4);
        check_sdeg(course_error_o, 10'h3ff);
        check_sdeg(rudder_cmd_o, 10'h3ff);
        @(posedge clk_i);
        allowance_i <= 9'h001;
        wait_cyc(4);
        check_sdeg(rudder_cmd_o, 10'h000);
        adc_sample(12'h400);
        wait_cyc(4);
        check_sdeg(course_error_o, 10'h05a);
        check_sdeg(rudder_cmd_o, 10'h05a);
    endtask : t_heading

    task automatic t_selector();
        sel_pulses(12, 1'b1);
        sel_pulses(2, 1'b0);
        wait_cyc(100);
        check_deg(course_ref_o, 9'h00a);
        check_deg(set_course_o, 9'h00a);
    endtask : t_selector

    task automatic t_nav_accept();
        @(posedge clk_i);
        mode_nav_i <= 1'b1;
        rx.send_bearing(9'h014, 3);
        wait_cyc(120);
        check_deg(set_course_o, 9'h014);
        check_bit(display_b_valid_o, 1'b0);
        rx.send_bearing(9'h01e, 40);
        wait_cyc(120);
        check_deg(set_course_o, 9'h01e);
        check_sdeg(course_error_o, 10'h03c);
    endtask : t_nav_accept

    task automatic t_jump_ack();
        rx.send_bearing(9'h029, 2);
        wait_cyc(120);
        check_deg(set_course_o, 9'h01e);
        check_bit(display_b_valid_o, 1'b1);
        check_deg(display_b_o, 9'h029);
        @(posedge clk_i);
        mode_nav_i <= 1'b0;
        wait_cyc(8);
        check_deg(set_course_o, 9'h00a);
        @(posedge clk_i);
        mode_nav_i <= 1'b1;
        wait_cyc(8);
        check_deg(set_course_o, 9'h029);
        check_bit(display_b_valid_o, 1'b0);
    endtask : t_jump_ack

    task automatic t_cross_track();
        int k;
        k = 0;
        while (steer_cross_track_o !== 1'b1 && k < 1000) begin
            wait_cyc(1);
            k++;
        end
        check_bit(steer_cross_track_o, 1'b1);
        rx.send_cross_track_error(8'hfd, 5);
        wait_cyc(120);
        check_deg(set_course_o, 9'h026);
        rx.send_bearing(9'h02e, 5);
        wait_cyc(120);
        check_bit(steer_cross_track_o, 1'b1);
        check_deg(set_course_o, 9'h026);
        rx.send_bearing(9'h02f, 5);
        wait_cyc(90);
        check_bit(steer_cross_track_o, 1'b0);
        check_deg(set_course_o, 9'h02a);
    endtask : t_cross_track

    // An early repeat must not switch; a late one must, long before the forced timeout.
    task automatic t_still_message();
        rx.send_bearing(9'h02f, 1);
        wait_cyc(90);
        check_bit(steer_cross_track_o, 1'b0);
        rx.send_bearing(9'h02f, 140);
        wait_cyc(120);
        check_bit(steer_cross_track_o, 1'b1);
    endtask : t_still_message

    // A jump nobody answers must end its alarm on time and leave the course alone.
    task automatic t_alarm_expiry();
        rx.send_bearing(9'h03c, 2);
        wait_cyc(90);
        check_bit(display_b_valid_o, 1'b1);
        check_deg(display_b_o, 9'h03c);
        check_bit(alarm_o, 1'b0);
        wait_cyc(320);
        check_bit(display_b_valid_o, 1'b0);
        check_deg(set_course_o, 9'h02a);
    endtask : t_alarm_expiry

    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset_values();
        t_heading();
        t_selector();
        t_nav_accept();
        t_jump_ack();
        t_cross_track();
        t_still_message();
        t_alarm_expiry();
        give_verdict();
    end
endmodule : testbench
